// File: rtl/dtc_pkg.sv
package dtc_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam int unsigned AXI_AW   = 8;
  localparam logic [7:0]  OFS_MODE = 8'h00;  // timer_mode_reg
  localparam logic [7:0]  OFS_CTRL = 8'h04;  // timer_control_reg
  localparam logic [7:0]  OFS_CLK  = 8'h08;  // clock_control_reg
  localparam logic [7:0]  OFS_C0L  = 8'h0c;  // cnt0_low_byte
  localparam logic [7:0]  OFS_C0H  = 8'h10;  // cnt0_high_byte
  localparam logic [7:0]  OFS_C1L  = 8'h14;  // cnt1_low_byte
  localparam logic [7:0]  OFS_C1H  = 8'h18;  // cnt1_high_byte
  localparam logic [7:0]  OFS_ISTS = 8'h1c;  // Interrupt status, write one to clear
  localparam logic [7:0]  OFS_IMSK = 8'h20;  // Interrupt mask

  // Mode register field positions
  localparam int unsigned MD_T0_MODE = 0;    // Two bits: mode_sel_lo, mode_sel_hi
  localparam int unsigned MD_T0_FUNC = 2;    // 1 = count pin edges
  localparam int unsigned MD_T0_GATE = 3;    // 1 = qualify by ext_irq_pin0
  localparam int unsigned MD_T1_MODE = 4;
  localparam int unsigned MD_T1_FUNC = 6;
  localparam int unsigned MD_T1_GATE = 7;

  // Control and clock control bit positions
  localparam int unsigned CT_RUN0  = 0;      // run_bit0
  localparam int unsigned CT_RUN1  = 1;      // run_bit1
  localparam int unsigned CT_OVF0  = 2;      // overflow_flag0
  localparam int unsigned CT_OVF1  = 3;      // overflow_flag1
  localparam int unsigned CK_FAST0 = 0;      // fast_base_sel0
  localparam int unsigned CK_FAST1 = 1;      // fast_base_sel1

  // Values after reset
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [1:0]  RST_BITS = 2'h0;

  // Machine cycle timing: four states, slow base is three machine cycles
  localparam int unsigned STATES_PER_MC = 4;
  localparam int unsigned MC_PER_SLOW   = 3;
  localparam logic [1:0]  PH_C3         = 2'h2;
  localparam logic [1:0]  PH_C4         = 2'h3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Operating modes of one timer
  typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8R, DTC_MSPLIT} dtc_mode_t;

  // Result of one count step
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
  } dtc_step_t;

  // Machine cycle strobes
  typedef struct packed {
    logic c3;       // State C3 of every machine cycle
    logic c4;       // State C4 of every machine cycle
    logic fast_c3;  // Divide-by-four tick
    logic slow_c3;  // Divide-by-twelve tick
  } dtc_phase_t;

endpackage

// File: rtl/dtc_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_phase_gen #(
  parameter int unsigned STATES = dtc_pkg::STATES_PER_MC,  // States per machine cycle
  parameter int unsigned SLOW   = dtc_pkg::MC_PER_SLOW     // Machine cycles per slow tick
) (
  input  wire logic              clk_sys,  // System clock
  input  wire logic              srst,     // Synchronous reset
  output dtc_pkg::dtc_phase_t    ph        // Phase strobes
);
  import dtc_pkg::*;

  // Refuse shapes the decode cannot serve
  if (STATES != 4 || SLOW < 1 || SLOW > 4) begin : g_shape_bad
    $error("dtc_phase_gen: unsupported phase shape");
  end

  logic [1:0] phase_r;  // Current state C1..C4
  logic [1:0] mc_r;     // Machine cycles within slow period

  // State counter, wraps every machine cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Machine cycle counter for the slow time base
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mc_r <= 2'h0;
    end else if (phase_r == PH_C4) begin
      mc_r <= (mc_r == 2'(SLOW - 1)) ? 2'h0 : mc_r + 2'h1;
    end
  end

  // Strobes from the counters
  assign ph.c3      = (phase_r == PH_C3);
  assign ph.c4      = (phase_r == PH_C4);
  assign ph.fast_c3 = (phase_r == PH_C3);
  assign ph.slow_c3 = (phase_r == PH_C3) && (mc_r == 2'(SLOW - 1));
endmodule
`default_nettype wire

// File: rtl/dtc_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_edge (
  input  wire logic clk_sys,  // System clock
  input  wire logic srst,     // Synchronous reset
  input  wire logic pin,      // Asynchronous pin
  input  wire logic c4,       // Sampling state strobe
  output logic      level,    // Filtered pin level
  output logic      fall      // Falling edge seen, held one machine cycle
);
  logic s1_r;    // First synchroniser stage
  logic s2_r;    // Second stage
  logic s3_r;    // Third stage
  logic samp_r;  // Level taken at the previous C4

  // Three-stage synchroniser
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Level changes only when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level <= 1'b1;
    end else if (s2_r == s3_r) begin
      level <= s3_r;
    end
  end

  // Sample at C4, high then low is a valid edge
  // Source must be slow enough for two samples per edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      samp_r <= 1'b1;
      fall   <= 1'b0;
    end else if (c4) begin
      samp_r <= level;
      fall   <= samp_r & ~level;
    end
  end
endmodule
`default_nettype wire

// File: rtl/dtc_top.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
  input  wire logic                      clk_sys,        // System clock, 40 MHz
  input  wire logic                      srst,           // Synchronous reset, high
  input  wire logic                      s_axi_awvalid,  // Write address valid
  output logic                           s_axi_awready,  // Write address ready
  input  wire logic [dtc_pkg::AXI_AW-1:0] s_axi_awaddr,  // Write address
  input  wire logic [2:0]                s_axi_awprot,   // Unused protection
  input  wire logic                      s_axi_wvalid,   // Write data valid
  output logic                           s_axi_wready,   // Write data ready
  input  wire logic [31:0]               s_axi_wdata,    // Write data
  input  wire logic [3:0]                s_axi_wstrb,    // Byte strobes
  output logic                           s_axi_bvalid,   // Write response valid
  input  wire logic                      s_axi_bready,   // Write response ready
  output logic [1:0]                     s_axi_bresp,    // Write response
  input  wire logic                      s_axi_arvalid,  // Read address valid
  output logic                           s_axi_arready,  // Read address ready
  input  wire logic [dtc_pkg::AXI_AW-1:0] s_axi_araddr,  // Read address
  input  wire logic [2:0]                s_axi_arprot,   // Unused protection
  output logic                           s_axi_rvalid,   // Read data valid
  input  wire logic                      s_axi_rready,   // Read data ready
  output logic [31:0]                    s_axi_rdata,    // Read data
  output logic [1:0]                     s_axi_rresp,    // Read response
  input  wire logic                      count_pin_zero, // Timer zero count pin
  input  wire logic                      count_pin_one,  // Timer one count pin
  input  wire logic                      ext_irq_pin0,   // Timer zero gate pin
  input  wire logic                      ext_irq_pin1,   // Timer one gate pin
  input  wire logic                      vec_ack0,       // Vectoring to timer zero
  input  wire logic                      vec_ack1,       // Vectoring to timer one
  output logic                           overflow_flag0, // Timer zero flag
  output logic                           overflow_flag1, // Timer one flag
  output logic                           baud_tick,      // Timer one overflow pulse
  output logic                           irq             // Masked interrupt level
);
  import dtc_pkg::*;

  // Count step of one timer for its mode
  function automatic dtc_step_t cnt_step(input dtc_mode_t m, input logic [7:0] lo,
                                         input logic [7:0] hi);
    dtc_step_t  r;
    logic [5:0] lo6;
    logic [16:0] w17;
    r   = '{lo: lo, hi: hi, ovf: 1'b0};
    lo6 = {1'b0, lo[4:0]} + 6'h01;
    w17 = {1'b0, hi, lo} + 17'h00001;
    unique case (m)
      DTC_M13: begin
        r.lo  = {lo[7:5], lo6[4:0]};
        r.hi  = hi + {7'h00, lo6[5]};
        r.ovf = lo6[5] & (hi == 8'hff);
      end
      DTC_M16: begin
        r.lo  = w17[7:0];
        r.hi  = w17[15:8];
        r.ovf = w17[16];
      end
      DTC_M8R: begin
        r.lo  = (lo == 8'hff) ? hi : lo + 8'h01;
        r.ovf = (lo == 8'hff);
      end
      DTC_MSPLIT: begin
        r.lo  = lo + 8'h01;
        r.ovf = (lo == 8'hff);
      end
    endcase
    return r;
  endfunction

  // Address decode shared by read and write
  function automatic logic addr_known(input logic [AXI_AW-1:0] a);
    return (a == OFS_MODE) || (a == OFS_CTRL) || (a == OFS_CLK) || (a == OFS_C0L) ||
           (a == OFS_C0H)  || (a == OFS_C1L)  || (a == OFS_C1H) || (a == OFS_ISTS) ||
           (a == OFS_IMSK);
  endfunction

  // Software state
  logic [7:0]        mode_r;     // timer_mode_reg
  logic              run0_r;     // run_bit0
  logic              run1_r;     // run_bit1
  logic              ovf0_r;     // overflow_flag0
  logic              ovf1_r;     // overflow_flag1
  logic              fast0_r;    // fast_base_sel0
  logic              fast1_r;    // fast_base_sel1
  logic [7:0]        c0l_r;      // cnt0_low_byte
  logic [7:0]        c0h_r;      // cnt0_high_byte
  logic [7:0]        c1l_r;      // cnt1_low_byte
  logic [7:0]        c1h_r;      // cnt1_high_byte
  logic [1:0]        ists_r;     // Sticky overflow events
  logic [1:0]        imsk_r;     // Interrupt mask
  logic              irq_r;      // Interrupt output
  logic              baud_r;     // Baud tick output

  // Bus slave state
  logic              aw_have_r;  // Write address held
  logic [AXI_AW-1:0] aw_addr_r;  // Held write address
  logic              w_have_r;   // Write data held
  logic [7:0]        w_byte_r;   // Held low data byte
  logic              w_lane_r;   // Low byte strobe held
  logic              awready_r;  // Write address ready
  logic              wready_r;   // Write data ready
  logic              bvalid_r;   // Write response valid
  logic [1:0]        bresp_r;    // Write response code
  logic              arready_r;  // Read address ready
  logic              rvalid_r;   // Read data valid
  logic [31:0]       rdata_r;    // Read data
  logic [1:0]        rresp_r;    // Read response code

  // Bus combinational terms
  logic              aw_take;    // Address handshake
  logic              w_take;     // Data handshake
  logic              ar_take;    // Read handshake
  logic              wr_go;      // Perform held write
  logic              aw_have_nxt;
  logic              w_have_nxt;
  logic              bvalid_nxt;
  logic              rvalid_nxt;
  logic              wr_en;      // Register write strobe
  logic [7:0]        rd_byte;    // Read mux result

  // Counting terms
  dtc_phase_t        ph;         // Machine cycle strobes
  logic              lvl_irq0;   // Gate pin levels
  logic              lvl_irq1;
  logic              fall_cnt0;  // Count pin edges
  logic              fall_cnt1;
  dtc_mode_t         md0;        // Timer zero mode
  dtc_mode_t         md1;        // Timer one mode
  logic              split;      // Timer zero in mode 3
  logic              base0;      // Time base ticks
  logic              base1;
  logic              en0;        // Counting enables
  logic              en1;
  logic              inc0;       // Increment strobes
  logic              inc0h;
  logic              inc1;
  dtc_step_t         st0;        // Next counts
  dtc_step_t         st1;
  logic              ovf0_evt;   // Overflow events
  logic              ovf1_evt;
  logic              t1_ovf;

  // Phase generator and pin conditioning
  dtc_phase_gen u_phase (
    .clk_sys (clk_sys),
    .srst    (srst),
    .ph      (ph)
  );

  dtc_pin_edge u_cnt0 (
    .clk_sys (clk_sys), .srst (srst), .pin (count_pin_zero), .c4 (ph.c4),
    .level   (),        .fall (fall_cnt0)
  );

  dtc_pin_edge u_cnt1 (
    .clk_sys (clk_sys), .srst (srst), .pin (count_pin_one), .c4 (ph.c4),
    .level   (),        .fall (fall_cnt1)
  );

  dtc_pin_edge u_irq0 (
    .clk_sys (clk_sys), .srst (srst), .pin (ext_irq_pin0), .c4 (ph.c4),
    .level   (lvl_irq0), .fall ()
  );

  dtc_pin_edge u_irq1 (
    .clk_sys (clk_sys), .srst (srst), .pin (ext_irq_pin1), .c4 (ph.c4),
    .level   (lvl_irq1), .fall ()
  );

  // Handshake terms of the bus slave
  always_comb begin
    aw_take     = s_axi_awvalid & awready_r;
    w_take      = s_axi_wvalid & wready_r;
    ar_take     = s_axi_arvalid & arready_r;
    wr_go       = aw_have_r & w_have_r & ~bvalid_r;
    aw_have_nxt = wr_go ? 1'b0 : (aw_have_r | aw_take);
    w_have_nxt  = wr_go ? 1'b0 : (w_have_r | w_take);
    bvalid_nxt  = wr_go | (bvalid_r & ~s_axi_bready);
    rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready);
    wr_en       = wr_go & w_lane_r & addr_known(aw_addr_r);
  end

  // Write channel capture and response
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_addr_r <= '0;
      w_byte_r  <= RST_BYTE;
      w_lane_r  <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awready_r <= ~aw_have_nxt & ~bvalid_nxt;
      wready_r  <= ~w_have_nxt & ~bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bresp_r <= addr_known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Read data mux
  always_comb begin
    unique case (s_axi_araddr)
      OFS_MODE: rd_byte = mode_r;
      OFS_CTRL: rd_byte = {4'h0, ovf1_r, ovf0_r, run1_r, run0_r};
      OFS_CLK:  rd_byte = {6'h00, fast1_r, fast0_r};
      OFS_C0L:  rd_byte = c0l_r;
      OFS_C0H:  rd_byte = c0h_r;
      OFS_C1L:  rd_byte = c1l_r;
      OFS_C1H:  rd_byte = c1h_r;
      OFS_ISTS: rd_byte = {6'h00, ists_r};
      OFS_IMSK: rd_byte = {6'h00, imsk_r};
      default:  rd_byte = 8'h00;  // Unmapped reads zero
    endcase
  end

  // Read channel
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= {24'h00_0000, rd_byte};
        rresp_r <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Mode, run and time base registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r  <= RST_BYTE;
      run0_r  <= 1'b0;
      run1_r  <= 1'b0;
      fast0_r <= 1'b0;
      fast1_r <= 1'b0;
      imsk_r  <= RST_BITS;
    end else if (wr_en) begin
      unique case (aw_addr_r)
        OFS_MODE: mode_r <= w_byte_r;
        OFS_CTRL: begin
          run0_r <= w_byte_r[CT_RUN0];
          run1_r <= w_byte_r[CT_RUN1];
        end
        OFS_CLK: begin
          fast0_r <= w_byte_r[CK_FAST0];
          fast1_r <= w_byte_r[CK_FAST1];
        end
        OFS_IMSK: imsk_r <= w_byte_r[1:0];
        default: ;
      endcase
    end
  end

  // Counting qualification and strobes
  always_comb begin
    md0   = dtc_mode_t'(mode_r[MD_T0_MODE +: 2]);
    md1   = dtc_mode_t'(mode_r[MD_T1_MODE +: 2]);
    split = (md0 == DTC_MSPLIT);
    base0 = fast0_r ? ph.fast_c3 : ph.slow_c3;
    base1 = fast1_r ? ph.fast_c3 : ph.slow_c3;
    en0   = run0_r & (~mode_r[MD_T0_GATE] | lvl_irq0);
    // Timer one loses its run bit while timer zero is split
    en1   = (split | run1_r) & (~mode_r[MD_T1_GATE] | lvl_irq1)
            & (md1 != DTC_MSPLIT);
    // Pin edges are consumed at the C3 after detection
    inc0  = en0 & (mode_r[MD_T0_FUNC] ? (ph.c3 & fall_cnt0) : base0);
    inc1  = en1 & (mode_r[MD_T1_FUNC] ? (ph.c3 & fall_cnt1) : base1);
    inc0h = split & run1_r & base0;
    st0   = cnt_step(md0, c0l_r, c0h_r);
    st1   = cnt_step(md1, c1l_r, c1h_r);
    t1_ovf   = inc1 & st1.ovf;
    ovf0_evt = inc0 & st0.ovf;
    ovf1_evt = split ? (inc0h & (c0h_r == 8'hff)) : t1_ovf;
  end

  // Timer zero count bytes, a write beats an increment
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      c0l_r <= RST_BYTE;
      c0h_r <= RST_BYTE;
    end else begin
      if (wr_en && aw_addr_r == OFS_C0L) begin
        c0l_r <= w_byte_r;
      end else if (inc0) begin
        c0l_r <= st0.lo;
      end
      if (wr_en && aw_addr_r == OFS_C0H) begin
        c0h_r <= w_byte_r;
      end else if (inc0h) begin
        c0h_r <= c0h_r + 8'h01;
      end else if (inc0) begin
        c0h_r <= st0.hi;
      end
    end
  end

  // Timer one count bytes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      c1l_r <= RST_BYTE;
      c1h_r <= RST_BYTE;
    end else begin
      if (wr_en && aw_addr_r == OFS_C1L) begin
        c1l_r <= w_byte_r;
      end else if (inc1) begin
        c1l_r <= st1.lo;
      end
      if (wr_en && aw_addr_r == OFS_C1H) begin
        c1h_r <= w_byte_r;
      end else if (inc1) begin
        c1h_r <= st1.hi;
      end
    end
  end

  // Overflow flags: set wins over vectoring clear and software write
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ovf0_r <= 1'b0;
      ovf1_r <= 1'b0;
    end else begin
      if (ovf0_evt) begin
        ovf0_r <= 1'b1;
      end else if (wr_en && aw_addr_r == OFS_CTRL) begin
        ovf0_r <= w_byte_r[CT_OVF0];
      end else if (vec_ack0) begin
        ovf0_r <= 1'b0;
      end
      if (ovf1_evt) begin
        ovf1_r <= 1'b1;
      end else if (wr_en && aw_addr_r == OFS_CTRL) begin
        ovf1_r <= w_byte_r[CT_OVF1];
      end else if (vec_ack1) begin
        ovf1_r <= 1'b0;
      end
    end
  end

  // Baud tick from timer one overflow in every timer zero mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      baud_r <= 1'b0;
    end else begin
      baud_r <= t1_ovf;
    end
  end

  // Sticky status, write one to clear, set wins; masked interrupt
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ists_r <= RST_BITS;
      irq_r  <= 1'b0;
    end else begin
      ists_r <= {ovf1_evt, ovf0_evt} |
                (ists_r & ~((wr_en && aw_addr_r == OFS_ISTS) ? w_byte_r[1:0] : 2'h0));
      irq_r  <= |(ists_r & imsk_r);
    end
  end

  // Outputs straight from flip-flops
  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign overflow_flag0 = ovf0_r;
  assign overflow_flag1 = ovf1_r;
  assign baud_tick      = baud_r;
  assign irq            = irq_r;
endmodule
`default_nettype wire

// File: verif/dtc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input  wire logic clk_sys,        // Clock
  output logic      count_pin_zero, // Count pin, idles high
  output logic      count_pin_one,  // Follows pin zero
  output logic      ext_irq_pin0,   // Gate pin zero
  output logic      ext_irq_pin1    // Gate pin one
);
  assign count_pin_one = count_pin_zero;
  // Pins idle high
  initial begin
    count_pin_zero = 1'b1;
    ext_irq_pin0   = 1'b1;
    ext_irq_pin1   = 1'b1;
  end
  // Gate pin zero level, single driver here
  task automatic gate0(input logic v);
    ext_irq_pin0 <= v;
  endtask
  // Falling edges spaced 24 clocks apart
  task automatic falls(input int n);
    repeat (n) begin
      repeat (12) @(posedge clk_sys);
      count_pin_zero <= 1'b0;
      repeat (12) @(posedge clk_sys);
      count_pin_zero <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// File: verif/dtc_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_top_properties (
  input wire logic        clk_sys,        // Clock
  input wire logic        srst,           // Reset
  input wire logic        s_axi_awready,  // Aw ready
  input wire logic        s_axi_wready,   // W ready
  input wire logic        s_axi_bvalid,   // B valid
  input wire logic        s_axi_bready,   // B ready
  input wire logic        s_axi_arvalid,  // Ar valid
  input wire logic        s_axi_arready,  // Ar ready
  input wire logic        s_axi_rvalid,   // R valid
  input wire logic        s_axi_rready,   // R ready
  input wire logic [31:0] s_axi_rdata,    // R data
  input wire logic        vec_ack0,       // Vector zero
  input wire logic        vec_ack1,       // Vector one
  input wire logic        overflow_flag0, // Flag zero
  input wire logic        overflow_flag1, // Flag one
  input wire logic        baud_tick       // Baud pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  flag0_clear_a: assert property ($fell(overflow_flag0) |-> $past(vec_ack0) || $rose(s_axi_bvalid))
    else $error("flag zero dropped without cause");
  flag1_clear_a: assert property ($fell(overflow_flag1) |-> $past(vec_ack1) || $rose(s_axi_bvalid))
    else $error("flag one dropped without cause");
  baud_gap_a: assert property (baud_tick |=> !baud_tick [*3])
    else $error("baud ticks too close");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule
bind dtc_top dtc_top_properties i_props (.clk_sys(clk_sys), .srst(srst),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .vec_ack0(vec_ack0), .vec_ack1(vec_ack1), .overflow_flag0(overflow_flag0),
  .overflow_flag1(overflow_flag1), .baud_tick(baud_tick));
`default_nettype wire

// File: verif/dtc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dtc_top_test;
  import dtc_pkg::*;
  logic        clk_sys, srst, awv, wv, bre, arv, rre, va0, va1; // Bench drives
  logic        awr, wrd, bv, arr, rv, ovf0, ovf1, baud, irq;    // Design drives
  logic        p0, p1, g0, g1;                                  // Pin model drives
  logic [7:0]  awa, ara;                                        // Addresses
  logic [31:0] wd, rdat;                                        // Data
  logic [1:0]  brsp, rrsp;                                      // Responses
  int          failures, tests_run;                             // Tallies
  logic [23:0] tbl [3] = '{24'hff00e0, 24'hff0000, 24'ha5a5a0}; // Hi, hi after, lo after masked
  dtc_top i_dut (.clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_bresp(brsp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rdat),
    .s_axi_rresp(rrsp), .count_pin_zero(p0), .count_pin_one(p1), .ext_irq_pin0(g0),
    .ext_irq_pin1(g1), .vec_ack0(va0), .vec_ack1(va1), .overflow_flag0(ovf0),
    .overflow_flag1(ovf1), .baud_tick(baud), .irq(irq));
  dtc_pin_model i_pins (.clk_sys(clk_sys), .count_pin_zero(p0), .count_pin_one(p1),
    .ext_irq_pin0(g0), .ext_irq_pin1(g1));
  // Verdict and end of run
  task automatic finish_test();
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Compare and tally
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  // Wait for flag zero, flag one or baud tick; n counts edges
  task automatic wt(input int k, input int lim, output int n);
    n = 0;
    do begin @(posedge clk_sys); n++; end
    while ((k == 0 ? ovf0 : k == 1 ? ovf1 : baud) !== 1'b1 && n < lim);
    if (n >= lim) begin failures++; finish_test(); end
  endtask
  // Register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, dd;
    int n;
    ad = 0; dd = 0; n = 0;
    awa <= a; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    while (!(ad && dd) && n < 50) begin
      @(posedge clk_sys); n++;
      if (awr && !ad) begin ad = 1; awv <= 1'b0; end
      if (wrd && !dd) begin dd = 1; wv <= 1'b0; end
    end
    do begin @(posedge clk_sys); n++; end while (!bv && n < 50);
    if (n >= 50) begin failures++; finish_test(); end
  endtask
  // Register read
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (!arr && n < 50);
    arv <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (!rv && n < 50);
    d = rdat; r = rrsp;
    if (n >= 50) begin failures++; finish_test(); end
  endtask
  // Clock, 25 ns
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] r;
    failures = 0; tests_run = 0; srst = 1'b1; awa = 8'h0; ara = 8'h0; wd = 32'h0;
    {awv, wv, bre, arv, rre, va0, va1} = 7'h0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a <= 32; a += 4) begin rd(a[7:0], d, r); chk(d, 32'h0); end
    rd(8'h24, d, r); chk(r, RESP_SLVERR);
    wr(8'h24, 8'h00); chk(brsp, RESP_SLVERR);
    // Overflow in modes 0, 1 and 2 on the fast base
    wr(OFS_CLK, 8'h03);
    foreach (tbl[i]) begin
      wr(OFS_CTRL, 8'h00); wr(OFS_C0L, 8'hff); wr(OFS_C0H, tbl[i][23:16]);
      wr(OFS_MODE, {6'h0, i[1:0]}); wr(OFS_CTRL, 8'h01);
      wt(0, 300, n);
      wr(OFS_CTRL, 8'h04);
      rd(OFS_C0H, d, r); chk(d[7:0], tbl[i][15:8]);
      rd(OFS_C0L, d, r); chk(d[7:0] & 8'he0, tbl[i][7:0]);
    end
    // Interrupt masked, raised, cleared; vectoring drops the flag
    chk(irq, 1'b0);
    wr(OFS_IMSK, 8'h01); @(posedge clk_sys); chk(irq, 1'b1);
    va0 <= 1'b1; va1 <= 1'b1; @(posedge clk_sys);
    va0 <= 1'b0; va1 <= 1'b0; @(posedge clk_sys); chk(ovf0, 1'b0);
    wr(OFS_ISTS, 8'h01); @(posedge clk_sys); chk(irq, 1'b0);
    // Pin edges counted only while the gate pin is high
    wr(OFS_CTRL, 8'h00); wr(OFS_C0L, 8'hfc); wr(OFS_C0H, 8'hfc); wr(OFS_MODE, 8'h0e);
    i_pins.gate0(1'b0); wr(OFS_CTRL, 8'h01);
    i_pins.falls(4); repeat (12) @(posedge clk_sys); chk(ovf0, 1'b0);
    i_pins.gate0(1'b1); i_pins.falls(4); wt(0, 40, n);
    // Timer one rate: four ticks per reload, slow then fast
    wr(OFS_CLK, 8'h01); wr(OFS_C1L, 8'hfc); wr(OFS_C1H, 8'hfc); wr(OFS_MODE, 8'h20);
    wr(OFS_CTRL, 8'h02); wt(2, 200, n); wt(2, 200, n); chk(n, 48);
    wr(OFS_CLK, 8'h03); wt(2, 200, n); wt(2, 200, n); chk(n, 16);
    // Split timer zero: high byte runs on run one and sets flag one
    wr(OFS_CTRL, 8'h00); wr(OFS_C0H, 8'hfe); wr(OFS_MODE, 8'h03); wr(OFS_CTRL, 8'h02);
    wt(1, 100, n);
    // Timer one in its own mode 3 holds its value
    wr(OFS_MODE, 8'h30); wr(OFS_C1L, 8'h5a); repeat (40) @(posedge clk_sys);
    rd(OFS_C1L, d, r); chk(d, 32'h5a);
    finish_test();
  end
endmodule
`default_nettype wire
